/* cwd_regs.sv */
// Watchdog set-up, diagnostic words, boot option and protocol statistics
//
// Contract
// - Timeout register counts in 100 ms units.
// - Mask bit (function code minus one) makes that code retrigger watchdog.
// - Changing the trigger register value starts the countdown.
// - Interval longer than timeout raises a watchdog timeout error.
// - Either stop key written to simple-stop halts the watchdog.
// - Stop key also clears the fault and unlocks configuration.
// - Read-only word shows current node error code.
// - Read-only word shows current error argument.
// - Read-only word shows output word image size in bits.
// - Read-only word shows input word image size in bits.
// - Read-only word shows digital output bit count.
// - Read-only word shows digital input bit count.
// - Boot word: 1 BootP, 2 DHCP, 4 stored settings.
// - Count internal bus failures, watchdog expiry included.
// - Count header, length, function, address and value errors separately.
// - Count requests over the register quantity limit.
// - Count requests over the coil quantity limit.
// - Two-word counter counts every received request.
// - Clear key written to statistics zeroes the whole area.
`timescale 1ns/1ps
module cwd_regs #(
   parameter int TICK_CYCLES = cwd_pkg::TICK_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata,
   output logic             reg_ack,
   output logic             reg_err,
   input  wire logic        req_valid,
   input  wire logic [7:0]  req_func,
   input  wire logic        bus_fault,
   input  wire logic        err_header,
   input  wire logic        err_length,
   input  wire logic        err_function,
   input  wire logic        err_address,
   input  wire logic        err_value,
   input  wire logic        err_reg_qty,
   input  wire logic        err_coil_qty,
   input  wire logic [15:0] node_error_code,
   input  wire logic [15:0] node_error_argument,
   input  wire logic [15:0] word_output_image_bits,
   input  wire logic [15:0] word_input_image_bits,
   input  wire logic [15:0] bit_output_image_count,
   input  wire logic [15:0] bit_input_image_count,
   output logic [15:0]      boot_address_source,
   output logic             wd_running,
   output logic             wd_fault
);
   import cwd_pkg::*;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [15:0]                 trigger;
      logic [15:0]                 timeout;
      logic [15:0]                 mask;
      logic [15:0]                 stop_word;
      logic [15:0]                 boot;
      logic [NUM_CNT-1:0][31:0]    cnt;
      cwd_wd_state_t               wd_state;
      logic                        running;
      logic                        fault;
      logic [15:0]                 rdata;
      logic                        ack;
      logic                        err;
   } cwd_st_t;

   cwd_st_t st_ff;
   cwd_st_t nxt_st;

   logic tmr_start;
   logic tmr_stop;
   logic tmr_kick;
   logic tmr_expire;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] sat_inc(input logic [31:0] v, input int idx);
      logic [31:0] lim;
      lim = (idx < NUM_SHORT) ? MAX_SHORT : MAX_LONG;
      sat_inc = (v == lim) ? v : v + 32'h00000001;
   endfunction

   // Statistics word k: three single words, low/high pairs, spare zero words
   function automatic logic [15:0] stat_word(input logic [NUM_CNT-1:0][31:0] c,
                                             input logic [4:0] k);
      logic [4:0] j;
      j = 5'h00;
      if (k < 5'(NUM_SHORT))
      begin
         stat_word = c[k][15:0];
      end
      else
      begin
         j = 5'(NUM_SHORT) + ((k - 5'(NUM_SHORT)) >> 1);
         if (j < 5'(NUM_CNT))
         begin
            stat_word = k[0] ? c[j][15:0] : c[j][31:16];
         end
         else
         begin
            stat_word = RST_WORD;
         end
      end
   endfunction

   function automatic logic is_key(input logic [15:0] v);
      is_key = (v == KEY_A) || (v == KEY_B);
   endfunction

   function automatic logic in_stats(input logic [15:0] a);
      in_stats = (a >= ADDR_STATS) && (a < ADDR_STATS + {11'h000, STATS_WORDS});
   endfunction

   function automatic logic is_diag(input logic [15:0] a);
      is_diag = (a >= ADDR_ERR_CODE) && (a <= ADDR_BIT_IN);
   endfunction

   // -----------------------------------------------------------------
   // Watchdog control strobes
   // -----------------------------------------------------------------
   logic wr_stop_key;
   logic wr_trig_change;
   logic func_hit;
   logic cfg_open;
   logic wd_trip;

   always_comb
   begin
      wr_stop_key    = reg_wr && (reg_addr == ADDR_WD_STOP) && is_key(reg_wdata);
      cfg_open       = (st_ff.wd_state != WD_RUNNING);
      wr_trig_change = reg_wr && (reg_addr == ADDR_WD_TRIGGER)
                       && (reg_wdata != st_ff.trigger);
      func_hit       = 1'b0;
      if ((req_func != 8'h00) && (req_func <= FUNC_MAX))
      begin
         func_hit = st_ff.mask[4'(req_func - 8'h01)];
      end
      tmr_start = wr_trig_change && !wr_stop_key && (st_ff.timeout != 16'h0000);
      tmr_stop  = wr_stop_key;
      tmr_kick  = req_valid && func_hit;
      wd_trip   = tmr_expire && (st_ff.wd_state == WD_RUNNING) && !tmr_start;
   end

   cwd_wd_timer #(
      .TICK_CYCLES   (TICK_CYCLES)
   ) u_timer (
      .sys_clk       (sys_clk),
      .rst_n         (rst_n),
      .start         (tmr_start),
      .stop          (tmr_stop),
      .kick          (tmr_kick),
      .timeout_units (st_ff.timeout),
      .expire        (tmr_expire)
   );

   // -----------------------------------------------------------------
   // Register and counter update
   // -----------------------------------------------------------------
   logic [NUM_CNT-1:0] ev;
   logic               clr;

   always_comb
   begin
      nxt_st       = st_ff;
      nxt_st.ack   = 1'b0;
      nxt_st.err   = 1'b0;
      nxt_st.rdata = st_ff.rdata;

      // -----------------------------------------------------------
      // Watchdog state
      // -----------------------------------------------------------
      case (st_ff.wd_state)
         WD_IDLE:
         begin
            if (tmr_start)
               nxt_st.wd_state = WD_RUNNING;
         end
         WD_RUNNING:
         begin
            if (wd_trip)
            begin
               nxt_st.wd_state = WD_EXHAUSTED;
               nxt_st.fault    = 1'b1;
            end
            else if (wr_stop_key)
               nxt_st.wd_state = WD_IDLE;
         end
         WD_EXHAUSTED:
         begin
            if (tmr_start)
               nxt_st.wd_state = WD_RUNNING;
            else if (wr_stop_key)
               nxt_st.wd_state = WD_IDLE;
         end
         default:
            nxt_st.wd_state = WD_IDLE;
      endcase
      if (wr_stop_key && !wd_trip)
         nxt_st.fault = 1'b0;
      nxt_st.running = (nxt_st.wd_state == WD_RUNNING);

      // -----------------------------------------------------------
      // Register writes
      // -----------------------------------------------------------
      if (reg_wr)
      begin
         nxt_st.ack = 1'b1;
         case (reg_addr)
            ADDR_WD_TRIGGER:
               nxt_st.trigger = reg_wdata;
            ADDR_WD_TIMEOUT:
            begin
               if (cfg_open)
                  nxt_st.timeout = reg_wdata;
            end
            ADDR_WD_MASK:
            begin
               if (cfg_open)
                  nxt_st.mask = reg_wdata;
            end
            ADDR_WD_STOP:
               nxt_st.stop_word = reg_wdata;
            ADDR_BOOT:
               nxt_st.boot = reg_wdata;
            default:
            begin
               nxt_st.err = !in_stats(reg_addr) && !is_diag(reg_addr);
            end
         endcase
      end

      // -----------------------------------------------------------
      // Statistics events
      // -----------------------------------------------------------
      ev[0] = bus_fault || wd_trip;
      ev[1] = err_header;
      ev[2] = err_length;
      ev[3] = err_function;
      ev[4] = err_address;
      ev[5] = err_value;
      ev[6] = err_reg_qty;
      ev[7] = err_coil_qty;
      ev[8] = req_valid;
      clr   = reg_wr && in_stats(reg_addr) && is_key(reg_wdata);
      for (int i = 0; i < NUM_CNT; i++)
      begin
         nxt_st.cnt[i] = clr ? 32'h00000000 : st_ff.cnt[i];
         if (ev[i])
            nxt_st.cnt[i] = sat_inc(nxt_st.cnt[i], i);
      end

      // -----------------------------------------------------------
      // Register reads
      // -----------------------------------------------------------
      if (reg_rd && !reg_wr)
      begin
         nxt_st.ack = 1'b1;
         case (reg_addr)
            ADDR_WD_TRIGGER: nxt_st.rdata = st_ff.trigger;
            ADDR_WD_TIMEOUT: nxt_st.rdata = st_ff.timeout;
            ADDR_WD_MASK:    nxt_st.rdata = st_ff.mask;
            ADDR_WD_STOP:    nxt_st.rdata = st_ff.stop_word;
            ADDR_ERR_CODE:   nxt_st.rdata = node_error_code;
            ADDR_ERR_ARG:    nxt_st.rdata = node_error_argument;
            ADDR_WORD_OUT:   nxt_st.rdata = word_output_image_bits;
            ADDR_WORD_IN:    nxt_st.rdata = word_input_image_bits;
            ADDR_BIT_OUT:    nxt_st.rdata = bit_output_image_count;
            ADDR_BIT_IN:     nxt_st.rdata = bit_input_image_count;
            ADDR_BOOT:       nxt_st.rdata = st_ff.boot;
            default:
            begin
               if (in_stats(reg_addr))
               begin
                  nxt_st.rdata = stat_word(st_ff.cnt, 5'(reg_addr - ADDR_STATS));
               end
               else
               begin
                  nxt_st.rdata = RST_WORD;
                  nxt_st.err   = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_ff          <= '0;
         st_ff.boot     <= RST_BOOT;
         st_ff.wd_state <= WD_IDLE;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign reg_rdata           = st_ff.rdata;
   assign reg_ack             = st_ff.ack;
   assign reg_err             = st_ff.err;
   assign boot_address_source = st_ff.boot;
   assign wd_running          = st_ff.running;
   assign wd_fault            = st_ff.fault;

endmodule // cwd_regs

/* cwd_pkg.sv */
// Constants and types shared by the coupler watchdog and diagnostic register bank
package cwd_pkg;

   // -----------------------------------------------------------------
   // Register word addresses
   // -----------------------------------------------------------------
   localparam logic [15:0] ADDR_WD_TRIGGER  = 16'h0003;
   localparam logic [15:0] ADDR_WD_TIMEOUT  = 16'h1000;
   localparam logic [15:0] ADDR_WD_MASK     = 16'h1001;
   localparam logic [15:0] ADDR_WD_STOP     = 16'h1008;
   localparam logic [15:0] ADDR_ERR_CODE    = 16'h1020;
   localparam logic [15:0] ADDR_ERR_ARG     = 16'h1021;
   localparam logic [15:0] ADDR_WORD_OUT    = 16'h1022;
   localparam logic [15:0] ADDR_WORD_IN     = 16'h1023;
   localparam logic [15:0] ADDR_BIT_OUT     = 16'h1024;
   localparam logic [15:0] ADDR_BIT_IN      = 16'h1025;
   localparam logic [15:0] ADDR_BOOT        = 16'h1028;
   localparam logic [15:0] ADDR_STATS       = 16'h1029;
   localparam logic [4:0]  STATS_WORDS      = 5'h11;

   // -----------------------------------------------------------------
   // Keys, codes and reset values
   // -----------------------------------------------------------------
   localparam logic [15:0] KEY_A            = 16'haa55;
   localparam logic [15:0] KEY_B            = 16'h55aa;
   localparam logic [15:0] BOOT_BOOTP       = 16'h0001;
   localparam logic [15:0] BOOT_DHCP        = 16'h0002;
   localparam logic [15:0] BOOT_STORED      = 16'h0004;
   localparam logic [15:0] RST_WORD         = 16'h0000;
   localparam logic [15:0] RST_BOOT         = 16'h0001;
   localparam logic [7:0]  FUNC_MAX         = 8'h10;

   // -----------------------------------------------------------------
   // Counter layout
   // -----------------------------------------------------------------
   localparam int          NUM_CNT          = 9;
   localparam int          NUM_SHORT        = 3;
   localparam logic [31:0] MAX_SHORT        = 32'h0000ffff;
   localparam logic [31:0] MAX_LONG         = 32'hffffffff;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int          CLK_HZ           = 40000000;
   localparam int          TICK_MS          = 100;
   localparam int          TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;

   typedef enum logic [1:0] {
      WD_IDLE,
      WD_RUNNING,
      WD_EXHAUSTED
   } cwd_wd_state_t;

endpackage

/* cwd_wd_timer.sv */
// Watchdog countdown in 100 ms units
`timescale 1ns/1ps
module cwd_wd_timer #(
   parameter int TICK_CYCLES = 4000000
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        start,
   input  wire logic        stop,
   input  wire logic        kick,
   input  wire logic [15:0] timeout_units,
   output logic             expire
);
   import cwd_pkg::*;

   typedef struct packed {
      logic        run;
      logic [31:0] presc;
      logic [15:0] units;
      logic        expire;
   } cwd_tmr_st_t;

   cwd_tmr_st_t st_ff;
   cwd_tmr_st_t nxt_st;

   // -----------------------------------------------------------------
   // Countdown
   // -----------------------------------------------------------------
   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.expire = 1'b0;
      if (stop)
      begin
         nxt_st.run = 1'b0;
      end
      else if (start || (kick && st_ff.run))
      begin
         nxt_st.run   = (timeout_units != 16'h0000);
         nxt_st.presc = 32'h00000000;
         nxt_st.units = timeout_units;
      end
      else if (st_ff.run)
      begin
         if (st_ff.presc == 32'(TICK_CYCLES - 1))
         begin
            nxt_st.presc = 32'h00000000;
            if (st_ff.units <= 16'h0001)
            begin
               nxt_st.run    = 1'b0;
               nxt_st.expire = 1'b1;
            end
            else
            begin
               nxt_st.units = st_ff.units - 16'h0001;
            end
         end
         else
         begin
            nxt_st.presc = st_ff.presc + 32'h00000001;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign expire = st_ff.expire;

endmodule // cwd_wd_timer

/* cwd_regs_monitor.sv */
// Concurrent checks on the watchdog and diagnostic register bank ports
`timescale 1ns/1ps
module cwd_regs_monitor (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic [15:0] node_error_code,
   input wire logic [15:0] node_error_argument,
   input wire logic [15:0] word_output_image_bits,
   input wire logic [15:0] boot_address_source,
   input wire logic        wd_running,
   input wire logic        wd_fault
);
   import cwd_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic rd_ok;
   logic stop_key;
   assign rd_ok    = reg_rd && !reg_wr;
   assign stop_key = reg_wr && reg_addr == ADDR_WD_STOP
                     && (reg_wdata == KEY_A || reg_wdata == KEY_B);
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_rd_err_code:
      assert property (rd_ok && reg_addr == ADDR_ERR_CODE |=> reg_rdata == $past(node_error_code))
      else $error("error code read mismatch");
   a_rd_err_arg:
      assert property (rd_ok && reg_addr == ADDR_ERR_ARG |=> reg_rdata == $past(node_error_argument))
      else $error("error argument read mismatch");
   a_rd_word_out:
      assert property (rd_ok && reg_addr == ADDR_WORD_OUT
                       |=> reg_rdata == $past(word_output_image_bits))
      else $error("output image size read mismatch");
   a_trig_starts:
      assert property ($rose(wd_running) |-> $past(reg_wr && reg_addr == ADDR_WD_TRIGGER))
      else $error("watchdog started without trigger write");
   a_expire_fault:
      assert property ($fell(wd_running) && $past(rst_n) && !$past(stop_key) |-> wd_fault)
      else $error("watchdog left running without fault");
   a_stop_halts:
      assert property (stop_key |=> !wd_running)
      else $error("stop key did not halt watchdog");
   a_stop_clears:
      assert property (stop_key && !wd_running |=> !wd_fault)
      else $error("stop key did not clear fault");
   a_boot_write:
      assert property (reg_wr && reg_addr == ADDR_BOOT |=> boot_address_source == $past(reg_wdata))
      else $error("boot word not updated");
   cover property ($rose(wd_fault));
   cover property (stop_key && wd_running);
   cover property (rd_ok && reg_addr == ADDR_STATS);
endmodule // cwd_regs_monitor

bind cwd_regs cwd_regs_monitor cwd_regs_monitor_i (.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata, .node_error_code, .node_error_argument, .word_output_image_bits,
   .boot_address_source, .wd_running, .wd_fault);

/* cwd_master_model.sv */
// Fieldbus master model issuing function-coded requests
`timescale 1ns/1ps
module cwd_master_model (
   input  wire logic        sys_clk,
   input  wire logic        en,
   input  wire logic [7:0]  func,
   input  wire logic [15:0] gap,
   output logic             req_valid,
   output logic [7:0]       req_func
);
   logic [15:0] cnt = 16'h0000;
   initial
   begin
      req_valid = 1'b0;
      req_func  = 8'h00;
   end
   // Requests spaced by gap cycles, code scrambled between them
   always @(negedge sys_clk)
   begin
      if (en && cnt >= gap)
      begin
         req_valid <= 1'b1;
         req_func  <= func;
         cnt       <= 16'h0000;
      end
      else
      begin
         req_valid <= 1'b0;
         req_func  <= req_func + 8'h3b;
         cnt       <= en ? cnt + 16'h0001 : 16'h0000;
      end
   end
endmodule // cwd_master_model

/* tb_top.sv */
// Self-checking bench for the watchdog and diagnostic register bank
`timescale 1ns/1ps
module tb_top;
   import cwd_pkg::*;
   logic        sys_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [15:0] reg_addr  = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic        reg_ack;
   logic        reg_err;
   logic        req_valid;
   logic [7:0]  req_func;
   logic [7:0]  ev        = 8'h00;
   logic [15:0] diag [6]  = '{16'h0a31, 16'h00c4, 16'h0040, 16'h0060, 16'h0011, 16'h0021};
   logic [15:0] boot_address_source;
   logic        wd_running;
   logic        wd_fault;
   logic        m_en      = 1'b0;
   logic [7:0]  m_func    = 8'h05;
   logic [15:0] trig      = 16'h0000;
   int          mismatches  = 0;
   int          checks_done = 0;
   int          req_seen    = 0;

   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (req_valid === 1'b1) req_seen++;

   cwd_regs #(.TICK_CYCLES(10)) cwd_regs_i (.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .req_valid, .req_func, .bus_fault(ev[0]),
      .err_header(ev[1]), .err_length(ev[2]), .err_function(ev[3]), .err_address(ev[4]),
      .err_value(ev[5]), .err_reg_qty(ev[6]), .err_coil_qty(ev[7]),
      .node_error_code(diag[0]), .node_error_argument(diag[1]),
      .word_output_image_bits(diag[2]), .word_input_image_bits(diag[3]),
      .bit_output_image_count(diag[4]), .bit_input_image_count(diag[5]),
      .boot_address_source, .wd_running, .wd_fault);
   cwd_master_model cwd_master_model_i (.sys_clk, .en(m_en), .func(m_func), .gap(16'h000f),
      .req_valid, .req_func);

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
      end
   endtask
   task acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
            output logic [15:0] q, output logic e);
      @(negedge sys_clk);
      reg_wr = wr; reg_rd = ~wr; reg_addr = a; reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0; reg_rd = 1'b0; q = reg_rdata; e = reg_err;
      chk(reg_ack, 1'b1, "access acknowledged");
   endtask
   task wr(input logic [15:0] a, input logic [15:0] d);
      logic [15:0] q;
      logic        e;
      acc(1'b1, a, d, q, e);
   endtask
   task rd(input logic [15:0] a, output logic [15:0] q);
      logic e;
      acc(1'b0, a, 16'h0000, q, e);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task t_reset;
      logic [15:0] q;
      logic        e;
      rd(ADDR_BOOT, q); chk(q, RST_BOOT, "boot reset");
      rd(ADDR_WD_TIMEOUT, q); chk(q, RST_WORD, "timeout reset");
      chk(wd_running, 1'b0, "idle after reset");
      acc(1'b0, 16'h1010, 16'h0000, q, e); chk({e, q}, 17'h10000, "unmapped read");
      $display("test reset done");
   endtask
   task t_diag;
      logic [15:0] q;
      for (int i = 0; i < 6; i++)
      begin
         rd(ADDR_ERR_CODE + 16'(i), q); chk(q, diag[i], "diag word");
      end
      wr(ADDR_ERR_CODE, 16'hffff); rd(ADDR_ERR_CODE, q); chk(q, diag[0], "read-only");
      $display("test diag done");
   endtask
   task t_boot;
      logic [15:0] q;
      logic [15:0] codes [4] = '{BOOT_DHCP, BOOT_STORED, BOOT_BOOTP, BOOT_DHCP};
      foreach (codes[i])
      begin
         wr(ADDR_BOOT, codes[i]); rd(ADDR_BOOT, q);
         chk(q, codes[i], "boot readback");
         chk(boot_address_source, codes[i], "boot port");
      end
      $display("test boot done");
   endtask
   task t_wd(input logic [7:0] f, input logic [15:0] m, input logic [15:0] key);
      logic [15:0] q;
      logic [15:0] b0;
      int          n;
      rd(ADDR_STATS, b0);
      wr(ADDR_WD_TIMEOUT, 16'h0003); wr(ADDR_WD_MASK, m); trig = trig + 16'h0001;
      wr(ADDR_WD_TRIGGER, trig); chk(wd_running, 1'b1, "started");
      m_func = f; m_en <= 1'b1;
      repeat (100) @(negedge sys_clk);
      chk(wd_running, 1'b1, "kept alive");
      wr(ADDR_WD_TIMEOUT, 16'h0007); rd(ADDR_WD_TIMEOUT, q); chk(q, 16'h0003, "locked");
      m_en <= 1'b0; n = 0;
      while (wd_fault !== 1'b1 && n < 40)
      begin
         @(negedge sys_clk); n++;
      end
      if (n == 40) begin mismatches++; end_of_test(); end
      chk(n >= 12 && n <= 33, 1'b1, "expiry time");
      chk(wd_running, 1'b0, "expired");
      rd(ADDR_STATS, q); chk(q, b0 + 16'h0001, "fault counted");
      wr(ADDR_WD_STOP, key); chk(wd_fault, 1'b0, "fault cleared");
      wr(ADDR_WD_TIMEOUT, 16'h0007); rd(ADDR_WD_TIMEOUT, q); chk(q, 16'h0007, "unlocked");
      trig = trig + 16'h0001; wr(ADDR_WD_TRIGGER, trig);
      wr(ADDR_WD_STOP, key); chk(wd_running, 1'b0, "stopped");
      $display("test watchdog done");
   endtask
   task t_stats;
      logic [15:0] q;
      logic [15:0] x;
      wr(ADDR_STATS, KEY_B); req_seen = 0;
      for (int i = 0; i < 8; i++)
         repeat (i + 1)
         begin
            @(negedge sys_clk) ev[i] = 1'b1;
            @(negedge sys_clk) ev[i] = 1'b0;
         end
      m_en <= 1'b1; repeat (40) @(negedge sys_clk); m_en <= 1'b0; repeat (2) @(negedge sys_clk);
      wr(ADDR_STATS + 16'h0002, 16'h1234);
      for (int w = 0; w < STATS_WORDS; w++)
      begin
         x = (w < 3) ? 16'(w + 1) : (w < 13 && w % 2 == 1) ? 16'((w - 3) / 2 + 4) : 16'h0000;
         if (w == 13) x = 16'(req_seen);
         rd(ADDR_STATS + 16'(w), q); chk(q, x, "counter");
      end
      wr(ADDR_STATS + 16'h0005, KEY_A);
      for (int w = 0; w < STATS_WORDS; w++)
      begin
         rd(ADDR_STATS + 16'(w), q); chk(q, 16'h0000, "cleared");
      end
      $display("test stats done");
   endtask

   initial
   begin
      #2000000;
      mismatches++;
      end_of_test();
   end
   initial
   begin
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      t_reset();
      t_diag();
      t_boot();
      t_wd(8'h05, 16'h0010, KEY_A);
      t_wd(8'h03, 16'h0004, KEY_B);
      t_stats();
      end_of_test();
   end
endmodule // tb_top
